// File: rtl/itwrc_target.sv
// i2c target that decodes the bus-wide software reset call
`timescale 1ns/1ps
`default_nettype none
module itwrc_target (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic soft_reset,
  output logic bus_busy
);
  // three-stage synchronisers, second and third must agree
  logic [itwrc_pkg::SYNC_STAGES-1:0] scl_sync;
  logic [itwrc_pkg::SYNC_STAGES-1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic scl_prev;
  logic sda_prev;
  logic next_scl_q;
  logic next_sda_q;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      scl_sync <= '1;
      sda_sync <= '1;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // filtered levels move only when stages two and three agree
  always_comb
  begin
    next_scl_q = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
    next_sda_q = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  // bus events; sda moving with scl high is control, not data
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise = scl_q && !scl_prev;
  assign scl_fall = !scl_q && scl_prev;
  assign start_seen = scl_q && scl_prev && sda_prev && !sda_q;
  assign stop_seen = scl_q && scl_prev && !sda_prev && sda_q;

  itwrc_pkg::itwrc_state_t state;
  itwrc_pkg::itwrc_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [1:0] data_idx;
  logic [1:0] next_data_idx;
  logic call_ok;
  logic next_call_ok;
  logic busy;
  logic next_busy;
  logic drive_low;
  logic next_drive_low;
  logic pulse;
  logic next_pulse;
  logic byte_ok;

  // does the byte just taken match the slot it arrived in
  always_comb
  begin
    unique case (data_idx)
      2'h0: byte_ok = (shreg == itwrc_pkg::RESET_CALL_ADDR);
      2'h1: byte_ok = (shreg == itwrc_pkg::RESET_BYTE_1);
      2'h2: byte_ok = (shreg == itwrc_pkg::RESET_BYTE_2);
      default: byte_ok = 1'b0;
    endcase
  end

  // bus state machine; acknowledge driven from the scl fall after bit 8
  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_data_idx = data_idx;
    next_call_ok = call_ok;
    next_busy = busy;
    next_drive_low = drive_low;
    next_pulse = 1'b0;
    if (stop_seen)
    begin
      next_pulse = call_ok && (data_idx == 2'h3);
      next_state = itwrc_pkg::ITWRC_IDLE;
      next_busy = 1'b0;
      next_drive_low = 1'b0;
      next_call_ok = 1'b0;
    end
    else if (start_seen)
    begin
      // repeated start also restarts the decode
      next_state = itwrc_pkg::ITWRC_SHIFT;
      next_busy = 1'b1;
      next_bit_cnt = 3'h0;
      next_data_idx = 2'h0;
      next_call_ok = 1'b0;
      next_drive_low = 1'b0;
    end
    else
    begin
      unique case (state)
        itwrc_pkg::ITWRC_IDLE:
        begin
          next_drive_low = 1'b0;
        end
        itwrc_pkg::ITWRC_SHIFT:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_q};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == itwrc_pkg::BIT_LAST)
              next_state = itwrc_pkg::ITWRC_ACK;
          end
        end
        itwrc_pkg::ITWRC_ACK:
        begin
          // on the fall after bit 8 decide and drive the acknowledge
          if (scl_fall && !drive_low)
          begin
            if (byte_ok)
            begin
              next_drive_low = 1'b1;
              next_call_ok = (data_idx == itwrc_pkg::DATA_IDX_MAX) ? 1'b1 : 1'b0;
              next_data_idx = data_idx + 2'h1;
            end
            else
            begin
              // any mismatch aborts the call until the next start
              next_state = itwrc_pkg::ITWRC_IGNORE;
              next_call_ok = 1'b0;
              next_data_idx = 2'h3;
            end
          end
          else if (scl_fall && drive_low)
          begin
            // acknowledge pulse done: release and take the next byte; a byte after
            // the second is still clocked in so that its refusal cancels the call
            next_drive_low = 1'b0;
            next_state = itwrc_pkg::ITWRC_SHIFT;
          end
        end
        itwrc_pkg::ITWRC_IGNORE:
        begin
          next_drive_low = 1'b0;
        end
        default:
        begin
          next_state = itwrc_pkg::ITWRC_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  // read direction is refused at the address, so the sender states never arm
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || pulse)
    begin
      state <= itwrc_pkg::ITWRC_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      data_idx <= 2'h0;
      call_ok <= 1'b0;
      busy <= 1'b0;
      drive_low <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      data_idx <= next_data_idx;
      call_ok <= next_call_ok;
      busy <= next_busy;
      drive_low <= next_drive_low;
      pulse <= next_pulse;
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign soft_reset = pulse;
  assign bus_busy = busy;

  // checks
  property p_ack_addr;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(drive_low) && (data_idx == 2'h1) |-> $past(shreg) == itwrc_pkg::RESET_CALL_ADDR;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("ack without reset address");
  property p_ack_b1;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(drive_low) && (data_idx == 2'h2) |-> $past(shreg) == itwrc_pkg::RESET_BYTE_1;
  endproperty
  a_ack_b1: assert property (p_ack_b1) else $error("ack of wrong first byte");
  property p_ack_b2;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(drive_low) && (data_idx == 2'h3) |-> $past(shreg) == itwrc_pkg::RESET_BYTE_2;
  endproperty
  a_ack_b2: assert property (p_ack_b2) else $error("ack of wrong second byte");
  property p_no_extra;
    @(posedge ref_clk) disable iff (!reset_n)
    state == itwrc_pkg::ITWRC_IGNORE |-> !sda_oe;
  endproperty
  a_no_extra: assert property (p_no_extra) else $error("drive after call");
  property p_reset_good;
    @(posedge ref_clk) disable iff (!reset_n)
    soft_reset |-> $past(stop_seen) && $past(call_ok) ##1 !soft_reset && state == itwrc_pkg::ITWRC_IDLE;
  endproperty
  a_reset_good: assert property (p_reset_good) else $error("bad soft reset");
  property p_no_bad_reset;
    @(posedge ref_clk) disable iff (!reset_n)
    stop_seen && !call_ok |=> !soft_reset;
  endproperty
  a_no_bad_reset: assert property (p_no_bad_reset) else $error("reset on bad call");
  property p_start;
    @(posedge ref_clk) disable iff (!reset_n)
    start_seen && !stop_seen |=> state == itwrc_pkg::ITWRC_SHIFT && bit_cnt == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not decoded");
  property p_ack_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    sda_oe && scl_rise |-> sda_oe [*2];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped in high");
  property p_hw_reset;
    @(posedge ref_clk) !reset_n |=> !sda_oe && !busy && state == itwrc_pkg::ITWRC_IDLE;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("reset not applied");
  c_soft: cover property (@(posedge ref_clk) disable iff (!reset_n) soft_reset);
  c_abort: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(state == itwrc_pkg::ITWRC_IGNORE));
  c_ack: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(sda_oe));
endmodule : itwrc_target
`default_nettype wire

// File: include/itwrc_pkg.sv
// shared constants for the i2c target with reset call
package itwrc_pkg;
  localparam logic [7:0] RESET_CALL_ADDR = 8'h96;
  localparam logic [7:0] RESET_BYTE_1 = 8'ha5;
  localparam logic [7:0] RESET_BYTE_2 = 8'h5a;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] DATA_IDX_MAX = 2'h2;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;
  typedef enum logic [2:0] {
    ITWRC_IDLE,
    ITWRC_SHIFT,
    ITWRC_ACK,
    ITWRC_SEND,
    ITWRC_RACK,
    ITWRC_IGNORE
  } itwrc_state_t;
endpackage : itwrc_pkg

// File: dv/itwrc_master.sv
// i2c controller model driving the target's bus pins
`timescale 1ns/1ps
`default_nettype none
module itwrc_master (
  input wire logic ref_clk,
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  logic drv_low = 1'b0;
  // open-drain wire with pull-up, so a released line reads high
  assign sda = ~(drv_low | sda_oe);
  initial scl = 1'b1;
  // quarter bit of 8 cycles keeps data 40 ns away from clock edges
  task wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  task start;
    drv_low = 1'b0;
    scl = 1'b1;
    wt(8);
    drv_low = 1'b1;
    wt(8);
    scl = 1'b0;
    wt(8);
  endtask : start
  // msb first, one bit per pulse, then the ack slot sampled all high phase
  task send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      drv_low = ~b[i];
      wt(8);
      scl = 1'b1;
      wt(16);
      scl = 1'b0;
      wt(8);
    end
    drv_low = 1'b0;
    ack = 1'b1;
    wt(8);
    scl = 1'b1;
    repeat (16)
    begin
      @(negedge ref_clk);
      ack = ack & ~sda;
    end
    scl = 1'b0;
    wt(8);
  endtask : send_byte
  task stop;
    drv_low = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(8);
    drv_low = 1'b0;
    wt(32);
  endtask : stop
endmodule : itwrc_master
`default_nettype wire

// File: dv/i2c_target_with_reset_call_test.sv
// self-checking bench for the reset call target
`timescale 1ns/1ps
`default_nettype none
module i2c_target_with_reset_call_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  wire logic scl;
  wire logic sda;
  logic sda_out;
  logic sda_oe;
  logic soft_reset;
  logic bus_busy;
  int fails = 0;
  int cmp_count = 0;
  int pulses = 0;
  // 200 mhz clock
  initial forever #2.5 ref_clk = ~ref_clk;
  itwrc_target u_itwrc_target (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .soft_reset(soft_reset),
    .bus_busy(bus_busy)
  );
  itwrc_master u_itwrc_master (
    .ref_clk(ref_clk),
    .sda_oe(sda_oe),
    .scl(scl),
    .sda(sda)
  );
  // count one-cycle reset pulses mid-cycle, away from the launching edge
  always @(negedge ref_clk)
  begin
    if (soft_reset === 1'b1)
      pulses++;
  end
  task chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask : chk
  // one framed transfer; a stop always closes it, even after a refusal
  task run_call(input logic [7:0] b [4], input int n, input logic [3:0] ea,
    input int ep, input string name);
    logic ack;
    int p0;
    p0 = pulses;
    u_itwrc_master.start();
    chk(bus_busy === 1'b1, "not busy after start");
    for (int i = 0; i < n; i++)
    begin
      u_itwrc_master.send_byte(b[i], ack);
      chk(ack === ea[i], "ack mismatch");
    end
    u_itwrc_master.stop();
    chk(bus_busy === 1'b0, "busy after stop");
    chk(pulses - p0 == ep, "reset pulse count");
    $display("test %s done", name);
  endtask : run_call
  task t_reset;
    repeat (3) @(negedge ref_clk);
    chk(sda_oe === 1'b0 && soft_reset === 1'b0 && bus_busy === 1'b0, "rst");
    chk(sda_out === 1'b0, "data value not low");
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(sda === 1'b1 && bus_busy === 1'b0, "not idle");
    $display("test reset done");
  endtask : t_reset
  // reset pulled in the middle of a call drops all progress
  task t_mid_reset;
    logic ack;
    int p0;
    p0 = pulses;
    u_itwrc_master.start();
    u_itwrc_master.send_byte(8'h96, ack);
    chk(ack === 1'b1, "address not acked");
    u_itwrc_master.send_byte(8'ha5, ack);
    chk(ack === 1'b1, "byte1 not acked");
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(sda_oe === 1'b0 && bus_busy === 1'b0, "mid reset not applied");
    reset_n = 1'b1;
    // let the preset synchronisers settle on the low clock before data moves
    repeat (8) @(negedge ref_clk);
    u_itwrc_master.send_byte(8'h5a, ack);
    chk(ack === 1'b0, "ack without a new start");
    u_itwrc_master.stop();
    chk(bus_busy === 1'b0, "busy after cut call");
    chk(pulses - p0 == 0, "reset after cut call");
    $display("test mid reset done");
  endtask : t_mid_reset
  task t_good;
    run_call('{8'h96, 8'ha5, 8'h5a, 8'h00}, 3, 4'h7, 1, "good");
    run_call('{8'h96, 8'ha5, 8'h5a, 8'h00}, 3, 4'h7, 1, "again");
  endtask : t_good
  task t_bad;
    run_call('{8'h97, 8'hff, 8'h5a, 8'h00}, 2, 4'h0, 0, "read");
    run_call('{8'h96, 8'ha4, 8'h5a, 8'h00}, 3, 4'h1, 0, "byte1");
    run_call('{8'h96, 8'ha5, 8'ha5, 8'h00}, 3, 4'h3, 0, "byte2");
    run_call('{8'h96, 8'ha5, 8'h5a, 8'h5a}, 4, 4'h7, 0, "extra");
  endtask : t_bad
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    t_reset();
    t_mid_reset();
    t_good();
    t_bad();
    print_verdict();
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    $display("unexpected %0t timeout", $time);
    print_verdict();
  end
endmodule : i2c_target_with_reset_call_test
`default_nettype wire
